// ---- design/host_regs_pkg.sv ----
// Package for the host-side status and control register bank.
// Assumes an 8-bit host register port with a five-bit location address.
package host_regs_pkg;

  // Host register locations.
  localparam logic [4:0] ADDR_WIDEBAND     = 5'h00;
  localparam logic [4:0] ADDR_INT_CTRL     = 5'h02;
  localparam logic [4:0] ADDR_CLK_DIV      = 5'h0A;
  localparam logic [4:0] ADDR_RSSI_RESULT  = 5'h0B;
  localparam logic [4:0] ADDR_BAT_RESULT   = 5'h0C;
  localparam logic [4:0] ADDR_LCD_CONTRAST = 5'h0D;
  localparam logic [4:0] ADDR_STATUS_CTRL  = 5'h0E;
  localparam logic [4:0] ADDR_TX_I_OFFSET  = 5'h0F;
  localparam logic [4:0] ADDR_TX_Q_OFFSET  = 5'h10;

  // Wide-band control field positions.
  localparam int WB_EDGE_LOCK_BIT = 7;
  localparam int WB_DEMOD_ON_BIT  = 6;
  localparam int WB_BW_MSB        = 5;
  localparam int WB_BW_LSB        = 3;

  // Interrupt control field positions.
  localparam int INT_CLEAR_WB_BIT = 7;
  localparam int INT_CLEAR_F_BIT  = 6;
  localparam int INT_CLEAR_D_BIT  = 5;
  localparam int INT_SEND_C_BIT   = 4;
  localparam int INT_GAIN_PWR_BIT = 3;
  localparam int INT_FREQ_PWR_BIT = 2;
  localparam int INT_FM_RX_BIT    = 1;

  // Status and control field positions.
  localparam int ST_OUT_OF_LOCK_BIT = 7;
  localparam int ST_TX_ON_BIT       = 6;
  localparam int ST_SYNTH_RDY_BIT   = 5;
  localparam int ST_CLK_OUT_EN_BIT  = 4;
  localparam int ST_CONV_RDY_BIT    = 3;
  localparam int ST_AUX_FS_MSB      = 2;
  localparam int ST_AUX_FS_LSB      = 1;
  localparam int ST_PA_GATE_BIT     = 0;

  // Offset trim and LCD contrast field positions.
  localparam int TRIM_MSB         = 5;
  localparam int LCD_LEVEL_MSB    = 7;
  localparam int LCD_LEVEL_LSB    = 4;
  localparam int LCD_ENABLE_N_BIT = 0;

  // Reset values.
  localparam logic [2:0] RST_LOOP_BW      = 3'h6;
  localparam logic [5:0] RST_CLK_DIV      = 6'h20;
  localparam logic       RST_CLK_OUT_EN   = 1'b1;
  localparam logic       RST_CONV_RDY     = 1'b1;
  localparam logic       RST_SYNTH_RDY    = 1'b1;
  localparam logic [3:0] RST_LCD_LEVEL    = 4'h0;
  localparam logic       RST_LCD_ENABLE_N = 1'b1;

endpackage : host_regs_pkg

// ---- design/host_status_control_regs.sv ----
// Host microcontroller status and control registers of the baseband interface.
// Assumes a synchronous host port: one-cycle read and write strobes, read data
// valid on the cycle after the read strobe, all inputs synchronous to core_clk.
//
// Overview of operation
// [R1] Reading location 00h returns the latest eight demodulated wide-band bits.
// [R2] Bit 7 of that byte is the newest bit; older bits sit lower.
// [R3] Writing 00h loads edge lock bit 7, demod on bit 6, bandwidth bits 5-3.
// [R4] Edge lock: 1 locks the edge detector, 0 unlocks; resets to 0.
// [R5] Demodulator on: 1 turns the wide-band demodulator on; resets to 0.
// [R6] Bandwidth code 000 is 20 Hz doubling to 110 at 1280 Hz; resets 110.
// [R7] Host clock divides the master clock by written bits 5-0.
// [R8] After reset the host clock divider divides by 32.
// [R9] Host writes only divide moduli 2 through 32, never 0 or 1.
// [R10] A new division takes effect only after the write strobe has ended.
// [R11] Interrupt bits 7-4: writing 1 acts, 0 does nothing; read 1 is pending.
// [R12] Interrupt bits 3-1 power gain DAC, frequency DAC, FM receive; reset 0.
// [R13] Out-of-lock reads its pin; in digital mode it blocks PA and transmit.
// [R14] Transmitter-on indicator reads the level on its input pin.
// [R15] Synthesizer ready reads 1 when programmable, 0 when busy; resets to 1.
// [R16] Clock output enable drives the master clock out when 1; resets to 1.
// [R17] Conversion ready sets on new result, clears on result read; resets 1.
// [R18] Bits 2-1 select auxiliary DAC full-scale range; reset to 0.
// [R19] While the PA gate bit is 0 the PA enable stays inactive; resets 0.
// [R20] Offset trims take a 6-bit two's-complement value in bits 5-0.
// [R21] LCD contrast level in bits 7-4, active-low enable in bit 0.
// [R22] Send-to-DSP raises the DSP message interrupt; only the DSP clears it.
// [R23] Location 00h reads wide-band data and writes demodulator control.
// [R24] Reserved bits ignore writes and read as zero.
`timescale 1ns/100ps

module host_status_control_regs (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Host register port
  input  wire logic [4:0] host_addr,
  input  wire logic [7:0] host_wdata,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  output logic      [7:0] host_rdata,
  // Wide-band demodulator
  input  wire logic       wb_bit,
  input  wire logic       wb_bit_valid,
  input  wire logic       wb_irq_event,
  output logic            edge_lock,
  output logic            demodulator_on,
  output logic      [2:0] loop_bandwidth_select,
  // Host clock
  output logic            host_clock_out,
  // Interrupts between host and DSP
  input  wire logic       dsp_clear_c,
  input  wire logic       dsp_clear_wb,
  input  wire logic       dsp_send_d,
  input  wire logic       dsp_send_f,
  output logic            dsp_message_irq,
  output logic            host_irq_wideband,
  output logic            host_irq_d,
  output logic            host_irq_f,
  // Power enables
  output logic            gain_dac_power,
  output logic            freq_dac_power,
  output logic            fm_receive_enable,
  // Status inputs
  input  wire logic       synth_out_of_lock,
  input  wire logic       tx_on_indicator,
  input  wire logic       synth_busy,
  input  wire logic       conversion_done,
  input  wire logic [7:0] rssi_result,
  input  wire logic [7:0] battery_result,
  // Transmit and analog controls
  input  wire logic       digital_mode,
  input  wire logic       tx_pa_request,
  output logic            pa_enable,
  output logic            tx_output_enable,
  output logic            clock_output_enable,
  output logic      [1:0] aux_dac_fullscale,
  output logic      [5:0] tx_i_offset,
  output logic      [5:0] tx_q_offset,
  output logic      [3:0] lcd_contrast_level,
  output logic            lcd_contrast_enable_n
);

  // Storage.
  logic [7:0] wb_data_reg;
  logic       edge_lock_reg;
  logic       demod_on_reg;
  logic [2:0] loop_bw_reg;
  logic [5:0] div_reg;
  logic [5:0] div_pend_reg;
  logic       div_pend_valid_reg;
  logic [5:0] div_cnt_reg;
  logic       host_clk_reg;
  logic       send_c_reg;
  logic       pend_wb_reg;
  logic       pend_d_reg;
  logic       pend_f_reg;
  logic [2:0] power_reg;
  logic       synth_rdy_reg;
  logic       clk_out_en_reg;
  logic       conv_rdy_reg;
  logic [1:0] aux_fs_reg;
  logic       pa_gate_reg;
  logic [5:0] tx_i_reg;
  logic [5:0] tx_q_reg;
  logic [3:0] lcd_level_reg;
  logic       lcd_en_n_reg;
  logic [7:0] rdata_reg;

  // Decode.
  function automatic logic hit(input logic [4:0] a, input logic [4:0] loc);
    hit = (a == loc);
  endfunction : hit

  wire wr_wb   = host_wr & hit(host_addr, host_regs_pkg::ADDR_WIDEBAND);
  wire wr_int  = host_wr & hit(host_addr, host_regs_pkg::ADDR_INT_CTRL);
  wire wr_div  = host_wr & hit(host_addr, host_regs_pkg::ADDR_CLK_DIV);
  wire wr_lcd  = host_wr & hit(host_addr, host_regs_pkg::ADDR_LCD_CONTRAST);
  wire wr_stat = host_wr & hit(host_addr, host_regs_pkg::ADDR_STATUS_CTRL);
  wire wr_txi  = host_wr & hit(host_addr, host_regs_pkg::ADDR_TX_I_OFFSET);
  wire wr_txq  = host_wr & hit(host_addr, host_regs_pkg::ADDR_TX_Q_OFFSET);
  wire rd_res  = host_rd & (hit(host_addr, host_regs_pkg::ADDR_RSSI_RESULT)
                          | hit(host_addr, host_regs_pkg::ADDR_BAT_RESULT));

  // Interrupt flags: a hardware set in the same cycle as a clear wins.
  wire send_c_next = (wr_int & host_wdata[host_regs_pkg::INT_SEND_C_BIT])
                   | (send_c_reg & ~dsp_clear_c); // [R22]
  wire pend_wb_next = wb_irq_event | (pend_wb_reg & ~dsp_clear_wb
                    & ~(wr_int & host_wdata[host_regs_pkg::INT_CLEAR_WB_BIT])); // [R11]
  wire pend_d_next = dsp_send_d
                   | (pend_d_reg & ~(wr_int & host_wdata[host_regs_pkg::INT_CLEAR_D_BIT]));
  wire pend_f_next = dsp_send_f
                   | (pend_f_reg & ~(wr_int & host_wdata[host_regs_pkg::INT_CLEAR_F_BIT]));
  wire conv_rdy_next = conversion_done | (conv_rdy_reg & ~rd_res); // [R17]

  // Host clock divider; the clock is high below the half point and low from it.
  wire       div_wrap     = (div_cnt_reg >= div_reg - 6'h01);
  wire [5:0] div_cnt_next = div_wrap ? 6'h00 : div_cnt_reg + 6'h01; // [R7]
  wire       apply_div    = div_pend_valid_reg & ~host_wr; // [R10]

  // Read mux; write-only and unmapped locations return zero.
  wire [7:0] int_view  = {pend_wb_reg, pend_f_reg, pend_d_reg, send_c_reg,
                          power_reg, 1'b0}; // [R11] [R24]
  wire [7:0] stat_view = {synth_out_of_lock, tx_on_indicator, synth_rdy_reg,
                          clk_out_en_reg, conv_rdy_reg, aux_fs_reg, pa_gate_reg}; // [R13] [R14]
  wire [7:0] rdata_next =
      hit(host_addr, host_regs_pkg::ADDR_WIDEBAND)     ? wb_data_reg : // [R1] [R23]
      hit(host_addr, host_regs_pkg::ADDR_INT_CTRL)     ? int_view :
      hit(host_addr, host_regs_pkg::ADDR_RSSI_RESULT)  ? rssi_result :
      hit(host_addr, host_regs_pkg::ADDR_BAT_RESULT)   ? battery_result :
      hit(host_addr, host_regs_pkg::ADDR_STATUS_CTRL)  ? stat_view : 8'h00; // [R24]

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wb_data_reg <= 8'h00;
    end else if (wb_bit_valid) begin
      wb_data_reg <= {wb_bit, wb_data_reg[7:1]}; // [R2]
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      edge_lock_reg <= 1'b0; // [R4]
      demod_on_reg  <= 1'b0; // [R5]
      loop_bw_reg   <= host_regs_pkg::RST_LOOP_BW; // [R6]
    end else if (wr_wb) begin
      edge_lock_reg <= host_wdata[host_regs_pkg::WB_EDGE_LOCK_BIT]; // [R3]
      demod_on_reg  <= host_wdata[host_regs_pkg::WB_DEMOD_ON_BIT];
      loop_bw_reg   <= host_wdata[host_regs_pkg::WB_BW_MSB:host_regs_pkg::WB_BW_LSB];
    end
  end

  // The modulus is swapped only once the strobe drops, so the host never
  // sees a clock edge derived from a half-written value.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_reg            <= host_regs_pkg::RST_CLK_DIV; // [R8]
      div_pend_reg       <= host_regs_pkg::RST_CLK_DIV;
      div_pend_valid_reg <= 1'b0;
      div_cnt_reg        <= 6'h00;
      host_clk_reg       <= 1'b0;
    end else begin
      if (wr_div) begin
        div_pend_reg       <= host_wdata[host_regs_pkg::TRIM_MSB:0]; // [R7]
        div_pend_valid_reg <= 1'b1;
      end else if (apply_div) begin
        div_pend_valid_reg <= 1'b0;
      end
      if (apply_div) begin
        div_reg     <= div_pend_reg; // [R10]
        div_cnt_reg <= 6'h00;
      end else begin
        div_cnt_reg <= div_cnt_next;
      end
      host_clk_reg <= (div_cnt_next < {1'b0, div_reg[5:1]});
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      send_c_reg  <= 1'b0;
      pend_wb_reg <= 1'b0;
      pend_d_reg  <= 1'b0;
      pend_f_reg  <= 1'b0;
      power_reg   <= 3'h0; // [R12]
    end else begin
      send_c_reg  <= send_c_next;
      pend_wb_reg <= pend_wb_next;
      pend_d_reg  <= pend_d_next;
      pend_f_reg  <= pend_f_next;
      if (wr_int) begin
        power_reg <= host_wdata[host_regs_pkg::INT_GAIN_PWR_BIT:host_regs_pkg::INT_FM_RX_BIT];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      synth_rdy_reg  <= host_regs_pkg::RST_SYNTH_RDY; // [R15]
      clk_out_en_reg <= host_regs_pkg::RST_CLK_OUT_EN; // [R16]
      conv_rdy_reg   <= host_regs_pkg::RST_CONV_RDY;
      aux_fs_reg     <= 2'h0; // [R18]
      pa_gate_reg    <= 1'b0; // [R19]
    end else begin
      synth_rdy_reg <= ~synth_busy; // [R15]
      conv_rdy_reg  <= conv_rdy_next;
      if (wr_stat) begin
        clk_out_en_reg <= host_wdata[host_regs_pkg::ST_CLK_OUT_EN_BIT]; // [R16]
        aux_fs_reg     <= host_wdata[host_regs_pkg::ST_AUX_FS_MSB:host_regs_pkg::ST_AUX_FS_LSB];
        pa_gate_reg    <= host_wdata[host_regs_pkg::ST_PA_GATE_BIT];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_i_reg      <= 6'h00;
      tx_q_reg      <= 6'h00;
      lcd_level_reg <= host_regs_pkg::RST_LCD_LEVEL;
      lcd_en_n_reg  <= host_regs_pkg::RST_LCD_ENABLE_N;
    end else begin
      if (wr_txi) begin
        tx_i_reg <= host_wdata[host_regs_pkg::TRIM_MSB:0]; // [R20]
      end
      if (wr_txq) begin
        tx_q_reg <= host_wdata[host_regs_pkg::TRIM_MSB:0]; // [R20]
      end
      if (wr_lcd) begin
        lcd_level_reg <= host_wdata[host_regs_pkg::LCD_LEVEL_MSB:host_regs_pkg::LCD_LEVEL_LSB];
        lcd_en_n_reg  <= host_wdata[host_regs_pkg::LCD_ENABLE_N_BIT]; // [R21]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (host_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs.
  wire tx_block = digital_mode & synth_out_of_lock; // [R13]
  assign pa_enable             = tx_pa_request & pa_gate_reg & ~tx_block; // [R19]
  assign tx_output_enable      = ~tx_block; // [R13]
  assign host_rdata            = rdata_reg;
  assign edge_lock             = edge_lock_reg;
  assign demodulator_on        = demod_on_reg;
  assign loop_bandwidth_select = loop_bw_reg;
  assign host_clock_out        = host_clk_reg;
  assign dsp_message_irq       = send_c_reg;
  assign host_irq_wideband     = pend_wb_reg;
  assign host_irq_d            = pend_d_reg;
  assign host_irq_f            = pend_f_reg;
  assign gain_dac_power        = power_reg[2];
  assign freq_dac_power        = power_reg[1];
  assign fm_receive_enable     = power_reg[0];
  assign clock_output_enable   = clk_out_en_reg;
  assign aux_dac_fullscale     = aux_fs_reg;
  assign tx_i_offset           = tx_i_reg;
  assign tx_q_offset           = tx_q_reg;
  assign lcd_contrast_level    = lcd_level_reg;
  assign lcd_contrast_enable_n = lcd_en_n_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_wb_shift_order: assert property (wb_bit_valid |=> // [R2]
      wb_data_reg == {$past(wb_bit), $past(wb_data_reg[7:1])})
    else $error("Wide-band data did not shift in at bit 7.");

  a_wb_read_back: assert property ( // [R1]
      host_rd && host_addr == host_regs_pkg::ADDR_WIDEBAND |=> host_rdata == $past(wb_data_reg))
    else $error("Wide-band read did not return the received bits.");

  a_ctrl_write_load: assert property (wr_wb |=> // [R3]
      {edge_lock, demodulator_on, loop_bandwidth_select} == $past(host_wdata[7:3]))
    else $error("Demodulator control not loaded from the write.");

  a_div_hold_write: assert property (host_wr |=> $stable(div_reg)) // [R10]
    else $error("Host clock modulus changed during a write.");

  a_div_apply_new: assert property ( // [R7]
      wr_div ##1 !host_wr |=> div_reg == $past(host_wdata[5:0], 2))
    else $error("Host clock modulus not applied after the write.");

  a_send_c_sticks: assert property ( // [R22]
      (wr_int && host_wdata[4]) ##1 (!dsp_clear_c)[*3] |-> dsp_message_irq)
    else $error("DSP message interrupt dropped without a DSP clear.");

  a_pa_gate_off: assert property (!pa_gate_reg |-> !pa_enable) // [R19]
    else $error("PA enable active while the host gate is off.");

  a_lock_blocks_tx: assert property ( // [R13]
      digital_mode && synth_out_of_lock |-> !pa_enable && !tx_output_enable)
    else $error("Transmit not blocked while synthesizer out of lock.");

  a_conv_read_clear: assert property ( // [R17]
      rd_res && !conversion_done |=> !conv_rdy_reg ##1 (host_rdata[3] == 1'b0
      || !$past(host_rd) || $past(host_addr) != host_regs_pkg::ADDR_STATUS_CTRL))
    else $error("Conversion ready not cleared by a result read.");

  a_int_reserved_zero: assert property ( // [R24]
      host_rd && host_addr == host_regs_pkg::ADDR_INT_CTRL |=> host_rdata[0] == 1'b0)
    else $error("Reserved interrupt bit read as one.");

  a_int_clear_wb: assert property ( // [R11]
      wr_int && host_wdata[host_regs_pkg::INT_CLEAR_WB_BIT] && !wb_irq_event
      |=> !host_irq_wideband)
    else $error("Wide-band interrupt not cleared by the host.");

  a_power_load: assert property (wr_int |=> // [R12]
      {gain_dac_power, freq_dac_power, fm_receive_enable} == $past(host_wdata[3:1]))
    else $error("Power enables not loaded from the write.");

  a_synth_rdy_track: assert property (1'b1 |=> synth_rdy_reg == !$past(synth_busy)) // [R15]
    else $error("Synthesizer ready does not follow the busy input.");

  a_conv_set_wins: assert property (conversion_done |=> conv_rdy_reg) // [R17]
    else $error("Conversion ready not set by a finished conversion.");

  a_trim_load: assert property (wr_txi |=> tx_i_offset == $past(host_wdata[5:0])) // [R20]
    else $error("Transmit I trim not loaded from the write.");

endmodule : host_status_control_regs

// ---- dv/host_mcu_model.sv ----
// Host microcontroller model for the register port of the bank.
// Assumes the bank samples strobes on the rising edge of core_clk.
`timescale 1ns/100ps

module host_mcu_model (
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic      [4:0] host_addr,
  output logic      [7:0] host_wdata,
  output logic            host_wr,
  output logic            host_rd,
  input  wire logic [7:0] host_rdata
);
  initial begin
    host_addr = 5'h00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end

  // Idle address and data are inverted, so a stale byte never matches by luck.
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    if (a === host_regs_pkg::ADDR_CLK_DIV && (d[5:0] < 6'h02 || d[5:0] > 6'h20)) begin
      return;
    end
    @(negedge core_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(negedge core_clk);
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(negedge core_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(negedge core_clk);
    host_rd <= 1'b0;
    host_addr <= ~a;
    d = host_rdata;
  endtask : rd_reg
endmodule : host_mcu_model

// ---- dv/host_status_control_regs_tb_top.sv ----
// Self-checking bench for the host status and control register bank.
// Assumes the host model owns the register port; the bench drives the rest.
`timescale 1ns/100ps

module host_status_control_regs_tb_top;
  typedef struct packed {
    logic [4:0] wa;
    logic [7:0] wd;
    logic [4:0] ra;
    logic [7:0] re;
  } row_t;

  // Write one location, read one back, expected byte.
  row_t rows [8] = '{
    '{5'h0E, 8'hFF, 5'h0E, 8'h3F}, '{5'h0E, 8'h00, 5'h0E, 8'h28},
    '{5'h02, 8'h0F, 5'h02, 8'h0E}, '{5'h02, 8'h01, 5'h02, 8'h00},
    '{5'h0D, 8'hF1, 5'h0D, 8'h00}, '{5'h0F, 8'hFF, 5'h0F, 8'h00},
    '{5'h1F, 8'hAA, 5'h1F, 8'h00}, '{5'h00, 8'hD7, 5'h00, 8'h00}};
  localparam logic [8:0] WB_SEQ = 9'h0CB;
  int mods [3] = '{2, 5, 32};
  logic       core_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [4:0] host_addr;
  logic [7:0] host_wdata, host_rdata, rssi_result, battery_result, d;
  logic       host_wr, host_rd, wb_bit, wb_bit_valid, edge_lock, demodulator_on;
  logic       synth_out_of_lock, tx_on_indicator, synth_busy, digital_mode, tx_pa_request;
  logic       host_clock_out, dsp_message_irq, host_irq_wideband, host_irq_d, host_irq_f;
  logic       gain_dac_power, freq_dac_power, fm_receive_enable, pa_enable;
  logic       tx_output_enable, clock_output_enable, lcd_contrast_enable_n;
  logic [5:0] ev, tx_i_offset, tx_q_offset;
  logic [2:0] loop_bandwidth_select;
  logic [1:0] aux_dac_fullscale;
  logic [3:0] lcd_contrast_level;
  int         mismatches = 0;
  int         n_checks = 0;
  int         i;
  wire [32:0] rst_view = {edge_lock, demodulator_on, loop_bandwidth_select, gain_dac_power,
    freq_dac_power, fm_receive_enable, clock_output_enable, aux_dac_fullscale, tx_i_offset,
    tx_q_offset, lcd_contrast_level, lcd_contrast_enable_n, dsp_message_irq,
    host_irq_wideband, host_irq_d, host_irq_f, pa_enable};
  wire [1:0]  pa_view = {pa_enable, tx_output_enable};

  always #2.5 core_clk = ~core_clk;

  host_mcu_model i_host (.core_clk, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata);

  host_status_control_regs i_dut (
    .core_clk, .sys_rst, .host_addr, .host_wdata, .host_wr, .host_rd, .host_rdata,
    .wb_bit, .wb_bit_valid, .wb_irq_event(ev[2]), .edge_lock, .demodulator_on,
    .loop_bandwidth_select, .host_clock_out, .dsp_clear_c(ev[3]), .dsp_clear_wb(ev[4]),
    .dsp_send_d(ev[0]), .dsp_send_f(ev[1]), .dsp_message_irq, .host_irq_wideband,
    .host_irq_d, .host_irq_f, .gain_dac_power, .freq_dac_power, .fm_receive_enable,
    .synth_out_of_lock, .tx_on_indicator, .synth_busy, .conversion_done(ev[5]),
    .rssi_result, .battery_result, .digital_mode, .tx_pa_request, .pa_enable,
    .tx_output_enable, .clock_output_enable, .aux_dac_fullscale, .tx_i_offset,
    .tx_q_offset, .lcd_contrast_level, .lcd_contrast_enable_n);

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(input int k);
    @(negedge core_clk);
    ev[k] = 1'b1;
    @(negedge core_clk);
    ev[k] = 1'b0;
  endtask : pulse

  // Settling cycles first, so no rise left over from the old modulus is counted.
  task automatic measure(input int n);
    int k;
    int t0;
    logic prev;
    repeat (3) @(posedge core_clk);
    #1;
    prev = host_clock_out;
    t0 = -1;
    for (k = 0; k < 200; k++) begin
      @(posedge core_clk);
      #1;
      if (prev === 1'b0 && host_clock_out === 1'b1 && t0 >= 0) break;
      if (prev === 1'b0 && host_clock_out === 1'b1) t0 = k;
      prev = host_clock_out;
    end
    if (k == 200) begin
      mismatches++;
      $display("[ERR] %0t host clock edge not seen", $time);
      tally_and_finish();
    end else begin
      chk(k - t0, n);
    end
  endtask : measure

  initial begin
    {wb_bit, wb_bit_valid, synth_out_of_lock, tx_on_indicator, synth_busy} = 5'h00;
    {digital_mode, ev} = 7'h00;
    tx_pa_request = 1'b1;
    rssi_result = 8'h5A;
    battery_result = 8'hA5;
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    chk(rst_view,
        {5'h06, 4'h1, 14'h0, 4'h0, 1'b1, 5'h00});
    measure(32);
    i_host.rd_reg(5'h0E, d);
    chk(d, 8'h38);
    for (i = 0; i < 8; i++) begin
      i_host.wr_reg(rows[i].wa, rows[i].wd);
      i_host.rd_reg(rows[i].ra, d);
      chk(d, rows[i].re);
    end
    chk({edge_lock, demodulator_on, loop_bandwidth_select, lcd_contrast_level,
         lcd_contrast_enable_n, tx_i_offset}, {5'h1A, 4'hF, 1'b1, 6'h3F});
    for (i = 0; i < 7; i++) begin
      i_host.wr_reg(5'h00, {2'b00, i[2:0], 3'b111});
      chk({edge_lock, demodulator_on, loop_bandwidth_select}, i);
    end
    for (i = 0; i < 9; i++) begin
      @(negedge core_clk);
      wb_bit = WB_SEQ[i];
      wb_bit_valid = 1'b1;
    end
    @(negedge core_clk);
    wb_bit_valid = 1'b0;
    i_host.rd_reg(5'h00, d);
    chk(d, 8'h65);
    for (i = 0; i < 3; i++) begin
      i_host.wr_reg(5'h0A, {2'b11, mods[i][5:0]});
      measure(mods[i]);
    end
    i_host.wr_reg(5'h02, 8'h10);
    i_host.wr_reg(5'h02, 8'hE0);
    i_host.rd_reg(5'h02, d);
    chk({dsp_message_irq, d}, 9'h110);
    pulse(3);
    chk(dsp_message_irq, 0);
    for (i = 0; i < 3; i++) begin
      pulse(i);
      i_host.rd_reg(5'h02, d);
      chk(d, 8'h20 << i);
      i_host.wr_reg(5'h02, 8'h20 << i);
      chk({host_irq_wideband, host_irq_f, host_irq_d}, 0);
    end
    i_host.wr_reg(5'h02, 8'h0A);
    chk({gain_dac_power, freq_dac_power, fm_receive_enable}, 3'b101);
    pulse(2);
    pulse(4);
    chk(host_irq_wideband, 0);
    // A wide-band event in the same cycle as its clear must leave it pending.
    @(negedge core_clk);
    ev[2] = 1'b1;
    ev[4] = 1'b1;
    @(negedge core_clk);
    ev = 6'h00;
    chk(host_irq_wideband, 1);
    pulse(4);
    {synth_out_of_lock, tx_on_indicator, synth_busy} = 3'b111;
    repeat (2) @(negedge core_clk);
    i_host.rd_reg(5'h0E, d);
    chk(d, 8'hC8);
    i_host.rd_reg(5'h0B, d);
    chk(d, 8'h5A);
    i_host.rd_reg(5'h0E, d);
    chk(d, 8'hC0);
    pulse(5);
    i_host.rd_reg(5'h0E, d);
    chk(d, 8'hC8);
    i_host.rd_reg(5'h0C, d);
    chk(d, 8'hA5);
    i_host.rd_reg(5'h0E, d);
    chk(d, 8'hC0);
    i_host.wr_reg(5'h0E, 8'h17);
    chk({pa_view, clock_output_enable, aux_dac_fullscale}, 5'h1F);
    digital_mode = 1'b1;
    #1 chk(pa_view, 2'b00);
    synth_out_of_lock = 1'b0;
    #1 chk(pa_view, 2'b11);
    i_host.wr_reg(5'h0E, 8'h00);
    chk({pa_view, clock_output_enable, aux_dac_fullscale}, 5'h08);
    i_host.wr_reg(5'h10, 8'hE0);
    i_host.wr_reg(5'h0D, 8'h5E);
    chk({tx_q_offset, lcd_contrast_level, lcd_contrast_enable_n}, 11'h40A);
    tally_and_finish();
  end
endmodule : host_status_control_regs_tb_top
